//--- shared/pdmc_pkg.sv
package pdmc_pkg;
	localparam int AXI_AW = 4;
	localparam logic [3:0] OFF_SYS_ONE = 4'h0;
	localparam logic [3:0] OFF_SYS_TWO = 4'h4;
	localparam logic [3:0] OFF_TIMER_A = 4'h8;
	localparam logic [3:0] OFF_STATUS = 4'hc;
	localparam int SYS1_STANDBY = 7;
	localparam int SYS1_SETTLE_LSB = 4;
	localparam int SYS1_LOW_SPEED = 3;
	localparam int SYS1_RSVD = 2;
	localparam int SYS1_MDIV_LSB = 0;
	localparam int SYS2_NOISE_SEL = 4;
	localparam int SYS2_DIRECT = 3;
	localparam int SYS2_MEDIUM = 2;
	localparam int SYS2_SDIV_LSB = 0;
	localparam int TMA_CLK_SRC = 3;
	localparam logic [7:0] SYS1_RESET = 8'h07;
	localparam logic [7:0] SYS2_RESET = 8'hf0;
	localparam logic [7:0] TMA_RESET = 8'h00;
	localparam logic [7:0] SYS1_FIXED_ONES = 8'h04;
	localparam logic [7:0] SYS2_FIXED_ONES = 8'he0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] SUB_DIV_8 = 2'h0;
	localparam logic [1:0] SUB_DIV_4 = 2'h1;
	localparam logic [1:0] SUB_DIV_2 = 2'h2;
	localparam int CYCLES_PER_STATE = 1;
	localparam int SETTLE_W = 18;
	localparam int unsigned SETTLE_STATES [8] = '{8192, 16384, 32768, 65536, 131072, 2, 8, 16};
	localparam int NUM_IRQ = 6;
	localparam int NUM_WKP = 8;
	localparam int SRC_IRQ0 = 0;
	localparam int SRC_IRQ1 = 1;
	localparam int SRC_TIMER_A = 2;
	localparam int SRC_TIMER_F = 3;
	localparam int SRC_TIMER_G = 4;
	localparam int SRC_OTHER = 5;
	localparam logic [5:0] STANDBY_WAKE_MASK = 6'h03;
	localparam logic [5:0] WATCH_WAKE_MASK = 6'h1d;
	typedef enum logic [3:0] {
		MODE_ACT_HI = 4'h0,
		MODE_ACT_MED = 4'h1,
		MODE_SUBACT = 4'h2,
		MODE_SLP_HI = 4'h3,
		MODE_SLP_MED = 4'h4,
		MODE_STANDBY = 4'h5,
		MODE_WATCH = 4'h6,
		MODE_SETTLE = 4'h7,
		MODE_RESET = 4'h8
	} pdmc_mode_t;
endpackage

//--- verilog/pdmc_sync.sv
`timescale 1ns/1ns
`default_nettype none
module pdmc_sync #(
	parameter int W = 1
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule
`default_nettype wire

//--- verilog/pdmc_settle.sv
`timescale 1ns/1ns
`default_nettype none
module pdmc_settle
	import pdmc_pkg::*;
#(
	parameter int unsigned CNT [8] = pdmc_pkg::SETTLE_STATES
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [2:0] code,
	output logic busy,
	output logic done
);
	logic [pdmc_pkg::SETTLE_W-1:0] cnt_q;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			cnt_q <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				cnt_q <= SETTLE_W'(CNT[code] * CYCLES_PER_STATE - 1);
				busy <= 1'b1;
			end else if (busy) begin
				if (cnt_q == '0) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					cnt_q <= cnt_q - 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- verilog/pdmc_ctrl.sv
// Operation
// - leaving standby, watch or sleep resumes active medium when medium select set.
// - subactive cpu clock is watch clock /8, /4, or /2 when upper bit set.
// - subactive clock select writes are ignored while in subactive mode.
// - sleep with all select bits zero enters high-speed sleep, peripherals run.
// - sleep with only medium select set enters medium-speed sleep.
// - any enabled interrupt ends sleep, starts exception, returns to matching active.
// - masked or disabled interrupts never end a low-power mode.
// - interrupt requests pass a two-flop synchroniser, at most two cycles added.
// - reset pin low during sleep clears sleep and holds cpu in reset.
// - sleep with standby set, low speed and timer source clear enters standby.
// - standby puts pins in high impedance except pulled-up pins.
// - only irq0, irq1, wake-up pins or reset pin end standby.
// - standby wake restarts oscillator, waits settle count, then exception and active.
// - reset pin in standby restarts oscillator; reset exception after release.
// - settle code selects 8192..131072, 2, 8 or 16 states of wait.
// - sleep with standby and timer source set enters watch; timers keep running.
// - watch ends only on timer a, f, g, irq0, wake-up pins or reset.
// - watch wake to active waits settle count before clock and exception.
// - watch wake with low speed set enters subactive on the subclock.
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module pdmc_ctrl #(
	parameter int unsigned SETTLE_CNT [8] = pdmc_pkg::SETTLE_STATES
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [pdmc_pkg::AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [pdmc_pkg::AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sleep_exec,
	input wire logic int_mask,
	input wire logic [pdmc_pkg::NUM_IRQ-1:0] irq_req,
	input wire logic [pdmc_pkg::NUM_IRQ-1:0] irq_en,
	input wire logic [pdmc_pkg::NUM_WKP-1:0] wakeup_pin,
	input wire logic [pdmc_pkg::NUM_WKP-1:0] wakeup_pin_en,
	input wire logic reset_pin_n,
	output pdmc_pkg::pdmc_mode_t mode,
	output logic cpu_halt,
	output logic periph_halt,
	output logic osc_run,
	output logic cpu_on_subclock,
	output logic [1:0] medium_div,
	output logic [1:0] sub_clock_div,
	output logic pins_hiz,
	output logic watch_timers_only,
	output logic cpu_reset,
	output logic int_exc_start
);
	import pdmc_pkg::*;

	logic [7:0] sys1_q;
	logic [7:0] sys2_q;
	logic [7:0] tma_q;
	pdmc_mode_t mode_q;
	pdmc_mode_t mode_d;
	pdmc_mode_t settle_target_q;
	logic [AXI_AW-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic wstrb0_q;
	logic aw_have_q;
	logic w_have_q;
	logic [NUM_IRQ-1:0] irq_s;
	logic [NUM_WKP-1:0] wkp_s;
	logic settle_start;
	logic settle_busy;
	logic settle_done;
	logic wake_sleep;
	logic wake_standby;
	logic wake_watch;
	logic exc_d;

	function automatic logic mapped(input logic [AXI_AW-1:0] a);
		mapped = (a == OFF_SYS_ONE) || (a == OFF_SYS_TWO) || (a == OFF_TIMER_A) ||
			(a == OFF_STATUS);
	endfunction

	function automatic pdmc_mode_t active_target(input logic med);
		active_target = med ? MODE_ACT_MED : MODE_ACT_HI;
	endfunction

	pdmc_sync #(.W(NUM_IRQ)) u_irq_sync (
		.core_clk(core_clk),
		.rst(rst),
		.async_in(irq_req),
		.sync_out(irq_s)
	);
	pdmc_sync #(.W(NUM_WKP)) u_wkp_sync (
		.core_clk(core_clk),
		.rst(rst),
		.async_in(wakeup_pin),
		.sync_out(wkp_s)
	);

	pdmc_settle #(.CNT(SETTLE_CNT)) u_settle (
		.core_clk(core_clk),
		.rst(rst),
		.start(settle_start),
		.code(sys1_q[SYS1_SETTLE_LSB +: 3]),
		.busy(settle_busy),
		.done(settle_done)
	);

	// mask and enable gate all wake sources
	always_comb begin
		wake_sleep = !int_mask && (|(irq_s & irq_en) || |(wkp_s & wakeup_pin_en));
		wake_standby = !int_mask &&
			(|(irq_s & irq_en & STANDBY_WAKE_MASK) || |(wkp_s & wakeup_pin_en));
		wake_watch = !int_mask &&
			(|(irq_s & irq_en & WATCH_WAKE_MASK) || |(wkp_s & wakeup_pin_en));
	end

	always_comb begin
		mode_d = mode_q;
		settle_start = 1'b0;
		exc_d = 1'b0;
		unique case (mode_q)
			MODE_ACT_HI, MODE_ACT_MED: begin
				if (sleep_exec) begin
					if (sys1_q[SYS1_STANDBY] && tma_q[TMA_CLK_SRC]) begin
						mode_d = MODE_WATCH;
					end else if (sys1_q[SYS1_STANDBY] && !sys1_q[SYS1_LOW_SPEED]) begin
						mode_d = MODE_STANDBY;
					end else if (!sys1_q[SYS1_STANDBY] && !sys1_q[SYS1_LOW_SPEED] &&
						!sys2_q[SYS2_DIRECT]) begin
						mode_d = sys2_q[SYS2_MEDIUM] ? MODE_SLP_MED : MODE_SLP_HI;
					end
				end
			end
			MODE_SUBACT: begin
				if (sleep_exec && sys1_q[SYS1_STANDBY] && tma_q[TMA_CLK_SRC]) begin
					mode_d = MODE_WATCH;
				end
			end
			MODE_SLP_HI, MODE_SLP_MED: begin
				if (wake_sleep) begin
					mode_d = (mode_q == MODE_SLP_MED) ? MODE_ACT_MED : MODE_ACT_HI;
					exc_d = 1'b1;
				end
			end
			MODE_STANDBY: begin
				if (wake_standby) begin
					mode_d = MODE_SETTLE;
					settle_start = 1'b1;
				end
			end
			MODE_WATCH: begin
				if (wake_watch) begin
					if (sys1_q[SYS1_LOW_SPEED]) begin
						mode_d = MODE_SUBACT;
						exc_d = 1'b1;
					end else begin
						mode_d = MODE_SETTLE;
						settle_start = 1'b1;
					end
				end
			end
			MODE_SETTLE: begin
				if (settle_done) begin
					mode_d = settle_target_q;
					exc_d = 1'b1;
				end
			end
			MODE_RESET: begin
				if (reset_pin_n) begin
					mode_d = MODE_ACT_HI;
				end
			end
			default: begin
				mode_d = MODE_ACT_HI;
			end
		endcase
		if (!reset_pin_n) begin
			mode_d = MODE_RESET;
			settle_start = 1'b0;
			exc_d = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			mode_q <= MODE_ACT_HI;
		end else begin
			mode_q <= mode_d;
		end
	end

	// active target chosen by medium select
	// watch wake to medium when selected
	always_ff @(posedge core_clk) begin
		if (rst) begin
			settle_target_q <= MODE_ACT_HI;
		end else if (settle_start) begin
			settle_target_q <= active_target(sys2_q[SYS2_MEDIUM]);
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			mode <= MODE_ACT_HI;
			cpu_halt <= 1'b0;
			periph_halt <= 1'b0;
			osc_run <= 1'b1;
			cpu_on_subclock <= 1'b0;
			pins_hiz <= 1'b0;
			watch_timers_only <= 1'b0;
			cpu_reset <= 1'b0;
			int_exc_start <= 1'b0;
		end else begin
			mode <= mode_d;
			cpu_halt <= !(mode_d inside {MODE_ACT_HI, MODE_ACT_MED, MODE_SUBACT});
			periph_halt <= mode_d inside {MODE_STANDBY, MODE_WATCH, MODE_SETTLE, MODE_RESET};
			osc_run <= !(mode_d inside {MODE_STANDBY, MODE_WATCH});
			cpu_on_subclock <= (mode_d == MODE_SUBACT);
			pins_hiz <= (mode_d == MODE_STANDBY);
			watch_timers_only <= (mode_d == MODE_WATCH);
			cpu_reset <= (mode_d == MODE_RESET);
			int_exc_start <= exc_d;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			medium_div <= 2'h3;
			sub_clock_div <= SUB_DIV_8;
		end else begin
			medium_div <= sys1_q[SYS1_MDIV_LSB +: 2];
			if (sys2_q[SYS2_SDIV_LSB + 1]) begin
				sub_clock_div <= SUB_DIV_2;
			end else begin
				sub_clock_div <= sys2_q[SYS2_SDIV_LSB] ? SUB_DIV_4 : SUB_DIV_8;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb0_q <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid && s_axi_awvalid;
			s_axi_wready <= !w_have_q && !s_axi_wready && !s_axi_bvalid && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb0_q <= s_axi_wstrb[0];
			end
			if (aw_have_q && w_have_q && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			sys1_q <= SYS1_RESET;
			sys2_q <= SYS2_RESET;
			tma_q <= TMA_RESET;
		end else if (aw_have_q && w_have_q && !s_axi_bvalid && wstrb0_q) begin
			unique case (awaddr_q)
				OFF_SYS_ONE: sys1_q <= wdata_q[7:0] | SYS1_FIXED_ONES;
				OFF_SYS_TWO: begin
					sys2_q[7:2] <= wdata_q[7:2] | SYS2_FIXED_ONES[7:2];
					if (mode_q != MODE_SUBACT) begin
						sys2_q[1:0] <= wdata_q[1:0];
					end
				end
				OFF_TIMER_A: tma_q <= wdata_q[7:0];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
				unique case (s_axi_araddr)
					OFF_SYS_ONE: s_axi_rdata <= {24'h000000, sys1_q};
					OFF_SYS_TWO: s_axi_rdata <= {24'h000000, sys2_q};
					OFF_TIMER_A: s_axi_rdata <= {24'h000000, tma_q};
					OFF_STATUS: s_axi_rdata <= {23'h000000, settle_busy, 4'h0, mode_q};
					default: s_axi_rdata <= '0;
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

//--- tb/pdmc_ctrl_properties.sv
`timescale 1ns/1ns
`default_nettype none
module pdmc_ctrl_props
	import pdmc_pkg::*;
#(
	parameter int unsigned SETTLE_CNT [8] = pdmc_pkg::SETTLE_STATES
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic int_mask,
	input wire logic [pdmc_pkg::NUM_IRQ-1:0] irq_req,
	input wire logic [pdmc_pkg::NUM_IRQ-1:0] irq_en,
	input wire logic reset_pin_n,
	input wire pdmc_pkg::pdmc_mode_t mode,
	input wire logic cpu_halt,
	input wire logic periph_halt,
	input wire logic osc_run,
	input wire logic pins_hiz,
	input wire logic watch_timers_only,
	input wire logic cpu_reset,
	input wire logic int_exc_start
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	property p_sleep_run;
		(mode == MODE_SLP_HI || mode == MODE_SLP_MED) |-> cpu_halt && !periph_halt;
	endproperty
	a_sleep_run: assert property (p_sleep_run) else $error("sleep halt wrong");
	property p_stby_stop;
		mode == MODE_STANDBY |-> cpu_halt && periph_halt && !osc_run;
	endproperty
	a_stby_stop: assert property (p_stby_stop) else $error("standby clock wrong");
	property p_stby_hiz;
		pins_hiz == (mode == MODE_STANDBY);
	endproperty
	a_stby_hiz: assert property (p_stby_hiz) else $error("pin state wrong");
	property p_watch;
		mode == MODE_WATCH |-> watch_timers_only && !pins_hiz;
	endproperty
	a_watch: assert property (p_watch) else $error("watch state wrong");
	property p_rst_pin;
		!reset_pin_n |=> mode == MODE_RESET && cpu_reset;
	endproperty
	a_rst_pin: assert property (p_rst_pin) else $error("reset pin ignored");
	property p_rst_osc;
		mode == MODE_RESET |-> osc_run && cpu_halt;
	endproperty
	a_rst_osc: assert property (p_rst_osc) else $error("osc off in reset");
	property p_mask;
		int_mask [*4] ##0 (mode == MODE_SLP_HI && reset_pin_n) |=> mode == MODE_SLP_HI;
	endproperty
	a_mask: assert property (p_mask) else $error("masked wake");
	property p_wake_sync;
		($rose(irq_req[0]) && irq_en[0] && !int_mask && mode == MODE_SLP_HI)
			|-> ##[1:3] mode == MODE_ACT_HI;
	endproperty
	a_wake_sync: assert property (p_wake_sync) else $error("wake too late");
	property p_exc_sleep;
		($past(mode) == MODE_SLP_HI && mode == MODE_ACT_HI) |-> int_exc_start;
	endproperty
	a_exc_sleep: assert property (p_exc_sleep) else $error("no exception");
	property p_settle_exc;
		($past(mode) == MODE_SETTLE && mode != MODE_SETTLE && mode != MODE_RESET)
			|-> int_exc_start && (mode == MODE_ACT_HI || mode == MODE_ACT_MED);
	endproperty
	a_settle_exc: assert property (p_settle_exc) else $error("settle exit wrong");
endmodule
bind pdmc_ctrl pdmc_ctrl_props #(.SETTLE_CNT(SETTLE_CNT)) u_props (.core_clk(core_clk),
	.rst(rst), .int_mask(int_mask), .irq_req(irq_req), .irq_en(irq_en),
	.reset_pin_n(reset_pin_n), .mode(mode), .cpu_halt(cpu_halt), .periph_halt(periph_halt),
	.osc_run(osc_run), .pins_hiz(pins_hiz), .watch_timers_only(watch_timers_only),
	.cpu_reset(cpu_reset), .int_exc_start(int_exc_start));
`default_nettype wire

//--- tb/pdmc_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module pdmc_cpu_model #(
	parameter int HOLD = 4
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic cpu_halt,
	input wire logic osc_run,
	input wire logic sleep_req,
	input wire logic rst_req,
	output logic sleep_exec,
	output logic reset_pin_n
);
	int osc_cnt_q;
	always_ff @(posedge core_clk) begin
		sleep_exec <= !rst && sleep_req && !cpu_halt;
	end
	always_ff @(posedge core_clk) begin
		if (rst || !osc_run) begin
			osc_cnt_q <= 0;
		end else if (osc_cnt_q < HOLD) begin
			osc_cnt_q <= osc_cnt_q + 1;
		end
		reset_pin_n <= rst || (!rst_req && (reset_pin_n || osc_cnt_q >= HOLD));
	end
endmodule
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
	import pdmc_pkg::*;
	localparam int unsigned CNT [8] = '{16, 16, 16, 16, 16, 2, 8, 16};
	logic core_clk = 1'b0, rst = 1'b1, sleep_req = 1'b0, rst_req = 1'b0, int_mask = 1'b0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, sleep_exec, reset_pin_n;
	logic [1:0] s_axi_bresp, s_axi_rresp, r, sub_clock_div, medium_div;
	logic [5:0] irq_req = 6'h00, irq_en = 6'h00;
	logic [7:0] wakeup_pin = 8'h00, wakeup_pin_en = 8'h00;
	logic cpu_halt, osc_run, cpu_on_subclock;
	logic [2:0] c;
	pdmc_mode_t mode;
	int checks = 0, bad_count = 0, n;
	pdmc_ctrl #(.SETTLE_CNT(CNT)) i_pdmc_ctrl (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sleep_exec, .int_mask,
		.irq_req, .irq_en, .wakeup_pin, .wakeup_pin_en, .reset_pin_n, .mode, .cpu_halt,
		.periph_halt(), .osc_run, .cpu_on_subclock, .medium_div, .sub_clock_div,
		.pins_hiz(), .watch_timers_only(), .cpu_reset(), .int_exc_start());
	pdmc_cpu_model i_pdmc_cpu_model (.core_clk, .rst, .cpu_halt, .osc_run, .sleep_req,
		.rst_req, .sleep_exec, .reset_pin_n);
	initial begin
		forever #2 core_clk = ~core_clk;
	end
	task test_done;
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task tmo(input int k);
		if (k >= 200) begin
			bad_count++;
			test_done();
		end
	endtask
	task tick(input int k);
		repeat (k) @(posedge core_clk);
	endtask
	task wr(input logic [3:0] a, input logic [7:0] v);
		int k;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		k = 0;
		do begin
			@(posedge core_clk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			k++;
		end while (s_axi_bvalid !== 1'b1 && k < 200);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		tmo(k);
	endtask
	task rd(input logic [3:0] a);
		int k;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		k = 0;
		do begin
			@(posedge core_clk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			k++;
		end while (s_axi_rvalid !== 1'b1 && k < 200);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		tmo(k);
	endtask
	task wm(input pdmc_mode_t m);
		n = 0;
		while (mode !== m && n < 200) begin
			@(posedge core_clk);
			n++;
		end
		tmo(n);
		chk(mode, m);
	endtask
	task slp;
		@(posedge core_clk);
		sleep_req <= 1'b1;
		@(posedge core_clk);
		sleep_req <= 1'b0;
	endtask
	initial begin
		tick(6);
		rst <= 1'b0;
		rd(OFF_SYS_ONE);
		chk(d, SYS1_RESET);
		rd(OFF_SYS_TWO);
		chk(d, SYS2_RESET);
		rd(4'h2);
		chk(r, RESP_SLVERR);
		chk(medium_div, SYS1_RESET[1:0]);
		wr(4'h2, 8'hff);
		chk(r, RESP_SLVERR);
		s_axi_wstrb <= 4'h0;
		wr(OFF_TIMER_A, 8'hff);
		s_axi_wstrb <= 4'hf;
		chk(r, RESP_OKAY);
		rd(OFF_TIMER_A);
		chk(d, TMA_RESET);
		for (int i = 0; i < 4; i++) begin
			wr(OFF_SYS_TWO, 8'(i));
			chk(r, RESP_OKAY);
			tick(2);
			chk(sub_clock_div, (i > 1) ? SUB_DIV_2 : ((i == 1) ? SUB_DIV_4 : SUB_DIV_8));
		end
		$display("test regs done");
		for (int m = 0; m < 2; m++) begin
			wr(OFF_SYS_TWO, {5'h0, m[0], 2'h0});
			slp();
			wm(m ? MODE_SLP_MED : MODE_SLP_HI);
			int_mask <= 1'b1;
			irq_en <= 6'h01;
			irq_req <= 6'h03;
			tick(8);
			chk(mode, m ? MODE_SLP_MED : MODE_SLP_HI);
			irq_req <= 6'h02;
			tick(4);
			int_mask <= 1'b0;
			tick(8);
			chk(mode, m ? MODE_SLP_MED : MODE_SLP_HI);
			irq_req <= 6'h01;
			wm(m ? MODE_ACT_MED : MODE_ACT_HI);
			chk(n <= 4, 1);
			irq_req <= 6'h00;
		end
		wr(OFF_SYS_TWO, 8'h00);
		slp();
		wm(MODE_SLP_HI);
		rst_req <= 1'b1;
		wm(MODE_RESET);
		rst_req <= 1'b0;
		wm(MODE_ACT_HI);
		$display("test sleep done");
		for (int k = 0; k < 4; k++) begin
			c = (k == 3) ? 3'h0 : 3'(k + 5);
			wr(OFF_SYS_TWO, (k == 1) ? 8'h04 : 8'h00);
			// code 5 for external clock, others crystal
			wr(OFF_SYS_ONE, {1'b1, c, 4'h0});
			slp();
			wm(MODE_STANDBY);
			chk(medium_div, 2'h0);
			irq_en <= 6'h3f;
			irq_req <= 6'h3c;
			tick(8);
			chk(mode, MODE_STANDBY);
			irq_req <= (k == 2) ? 6'h00 : 6'h02;
			wakeup_pin_en <= 8'h80;
			wakeup_pin <= (k == 2) ? 8'h80 : 8'h00;
			wm(MODE_SETTLE);
			wm((k == 1) ? MODE_ACT_MED : MODE_ACT_HI);
			chk(n, CNT[c] + 1);
			irq_req <= 6'h00;
			wakeup_pin <= 8'h00;
		end
		slp();
		wm(MODE_STANDBY);
		rst_req <= 1'b1;
		wm(MODE_RESET);
		chk(osc_run, 1'b1);
		rst_req <= 1'b0;
		wm(MODE_ACT_HI);
		$display("test standby done");
		wr(OFF_TIMER_A, 8'h08);
		for (int ls = 0; ls < 2; ls++) begin
			wr(OFF_SYS_ONE, {4'hf, ls[0], 3'h0});
			slp();
			wm(MODE_WATCH);
			irq_req <= 6'h22;
			tick(8);
			chk(mode, MODE_WATCH);
			irq_req <= 6'h04;
			wm(ls ? MODE_SUBACT : MODE_ACT_HI);
			irq_req <= 6'h00;
		end
		chk(cpu_on_subclock, 1'b1);
		wr(OFF_SYS_TWO, 8'h02);
		tick(2);
		chk(sub_clock_div, SUB_DIV_8);
		wr(OFF_SYS_ONE, 8'hf0);
		wr(OFF_SYS_TWO, 8'h04);
		slp();
		wm(MODE_WATCH);
		int_mask <= 1'b1;
		irq_req <= 6'h08;
		tick(8);
		chk(mode, MODE_WATCH);
		int_mask <= 1'b0;
		wm(MODE_ACT_MED);
		irq_req <= 6'h00;
		$display("test watch done");
		test_done();
	end
endmodule
`default_nettype wire
